// ==== inc/spc_defines.vh ====
`ifndef SPC_DEFINES_VH
`define SPC_DEFINES_VH
// ****************************************
// Register indices and byte addresses
// ****************************************
`define SPC_IDX_CTRL_TWO   16'h3099
`define SPC_ADDR_CTRL_TWO  16'hC264
`define SPC_ADDR_MODE      16'hC268
`define SPC_ADDR_IRQ_STAT  16'hC26C
`define SPC_ADDR_IRQ_MASK  16'hC270
// ****************************************
// Control two field positions
// ****************************************
`define SPC_C2_MATCH_IE    7
`define SPC_C2_UNIMPL      6
`define SPC_C2_RSVD_HI     5
`define SPC_C2_MODF_EN     4
`define SPC_C2_BIDIR_OE    3
`define SPC_C2_RSVD_LO     2
`define SPC_C2_STOP_WAIT   1
`define SPC_C2_SINGLE_WIRE 0
`define SPC_C2_WR_MASK     8'h9B
`define SPC_C2_RESET       8'h00
// ****************************************
// Mode, status and mask field positions
// ****************************************
`define SPC_MODE_MASTER    0
`define SPC_MODE_SEL_OE    1
`define SPC_MODE_RESET     2'h0
`define SPC_IRQ_MATCH      0
`define SPC_IRQ_FAULT      1
`define SPC_IRQ_RESET      2'h0
`endif

// ==== verilog/spc_sync.v ====
`timescale 1ns/10ps
`default_nettype none
module spc_sync #(
    parameter W = 4
) (
    input  wire         core_clk,
    input  wire         resetn,
    input  wire [W-1:0] asyncIn,
    output wire [W-1:0] syncOut
);
    // ****************************************
    // Two flop synchroniser per bit
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg stage1;
            reg stage2;
            // First stage is read only by the second
            always @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    stage1 <= 1'b0;
                    stage2 <= 1'b0;
                end else begin
                    stage1 <= asyncIn[i];
                    stage2 <= stage1;
                end
            end
            assign syncOut[i] = stage2;
        end
    endgenerate
endmodule // spc_sync
`default_nettype wire

// ==== verilog/spc_pin_ctrl.v ====
// Functional notes
// - Match flag with enable and mask bit raises interrupt
// - Bit six reads zero, writes ignored
// - Slave: fault enable ignored, select input
// - Master, fault off: select pin to GPIO
// - Master, fault on: fault input or select output
// - Select output enable picks output or fault
// - Master select one master, zero slave
// - Bidir enable ignored unless single wire
// - Bidir enable zero input, one output
// - Single wire: master MOSI, slave MISO
// - Stop in wait halts port clocks
// - Normal pins: roles by master or slave
// - Single wire master: MISO unused
// - Single wire slave: MOSI unused
`timescale 1ns/10ps
`default_nettype none
`include "spc_defines.vh"
module spc_pin_ctrl (
    input  wire        core_clk,
    input  wire        resetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [15:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Shifter side, same clock
    input  wire        matchEvent,
    input  wire        xferActive,
    input  wire        txBit,
    input  wire        cpuWait,
    output reg         rxBit,
    output reg         rxStrobe,
    output reg         portClkEn,
    output reg         irq,
    // Link pins
    input  wire        sckPin,
    input  wire        selectIn,
    output reg         selectOut,
    output reg         selectOe,
    output reg         selectGpio,
    input  wire        mosiIn,
    output reg         mosiOut,
    output reg         mosiOe,
    input  wire        misoIn,
    output reg         misoOut,
    output reg         misoOe
);
    // ****************************************
    // Declarations
    // ****************************************
    reg  [7:0]  ctrlTwo;
    reg  [1:0]  modeReg;
    reg  [1:0]  irqStat;
    reg  [1:0]  irqMask;
    reg         sckPrev;
    reg         faultPrev;
    wire [3:0]  pinSync;
    wire        sckSync;
    wire        selSync;
    wire        mosiSync;
    wire        misoSync;
    wire        isMaster;
    wire        mode_fault_enable;
    wire        selOe;
    wire        singleWire;
    wire        bidir_output_enable;
    wire        matchIe;
    wire        stopWait;
    wire        setupPh;
    wire        wrAcc;
    wire        hitCtrl;
    wire        hitMode;
    wire        hitStat;
    wire        hitMask;
    wire        hitAny;
    wire        sckRise;
    wire        faultLvl;
    wire [1:0]  irqSet;
    wire [1:0]  irqClr;
    reg  [31:0] next_prdata;
    reg         next_selectOut;
    reg         next_selectOe;
    reg         next_selectGpio;
    reg         next_mosiOut;
    reg         next_mosiOe;
    reg         next_misoOut;
    reg         next_misoOe;
    reg         next_rxBit;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    spc_sync #(
        .W(4)
    ) u_sync (
        .core_clk (core_clk),
        .resetn   (resetn),
        .asyncIn  ({sckPin, selectIn, mosiIn, misoIn}),
        .syncOut  (pinSync)
    );
    assign sckSync  = pinSync[3];
    assign selSync  = pinSync[2];
    assign mosiSync = pinSync[1];
    assign misoSync = pinSync[0];

    // ****************************************
    // Field decode
    // ****************************************
    assign isMaster   = modeReg[`SPC_MODE_MASTER];
    assign selOe      = modeReg[`SPC_MODE_SEL_OE];
    assign matchIe    = ctrlTwo[`SPC_C2_MATCH_IE];
    assign mode_fault_enable     = ctrlTwo[`SPC_C2_MODF_EN];
    assign bidir_output_enable    = ctrlTwo[`SPC_C2_BIDIR_OE];
    assign stopWait   = ctrlTwo[`SPC_C2_STOP_WAIT];
    assign singleWire = ctrlTwo[`SPC_C2_SINGLE_WIRE];

    // ****************************************
    // APB decode
    // ****************************************
    assign setupPh = psel & ~penable;
    assign wrAcc   = psel & penable & pready & pwrite;
    assign hitCtrl = (paddr == `SPC_ADDR_CTRL_TWO);
    assign hitMode = (paddr == `SPC_ADDR_MODE);
    assign hitStat = (paddr == `SPC_ADDR_IRQ_STAT);
    assign hitMask = (paddr == `SPC_ADDR_IRQ_MASK);
    assign hitAny  = hitCtrl | hitMode | hitStat | hitMask;

    // Read mux, sampled in the setup phase
    always @* begin
        next_prdata = 32'h0000_0000;
        if (hitCtrl) begin
            next_prdata[7:0] = ctrlTwo;
        end else if (hitMode) begin
            next_prdata[1:0] = modeReg;
        end else if (hitStat) begin
            next_prdata[1:0] = irqStat;
        end else if (hitMask) begin
            next_prdata[1:0] = irqMask;
        end
    end

    // One access cycle, error on unmapped address
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setupPh;
            pslverr <= setupPh & ~hitAny;
            if (setupPh && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    // Bit six and the reserved bits stay zero
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrlTwo <= `SPC_C2_RESET;
            modeReg <= `SPC_MODE_RESET;
            irqMask <= `SPC_IRQ_RESET;
        end else if (wrAcc) begin
            if (hitCtrl) begin
                ctrlTwo <= pwdata[7:0] & `SPC_C2_WR_MASK;
            end
            if (hitMode) begin
                modeReg <= pwdata[1:0];
            end
            if (hitMask) begin
                irqMask <= pwdata[1:0];
            end
        end
    end

    // ****************************************
    // Events and interrupt
    // ****************************************
    // Mode fault: master, fault on, select is input and low
    assign faultLvl = isMaster & mode_fault_enable & ~selOe & ~selSync;
    assign irqSet   = {faultLvl & ~faultPrev, matchEvent};
    assign irqClr   = (wrAcc && hitStat) ? pwdata[1:0] : 2'h0;

    // Sticky flags, a new event beats a clear
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            irqStat   <= `SPC_IRQ_RESET;
            faultPrev <= 1'b0;
            irq       <= 1'b0;
        end else begin
            irqStat   <= (irqStat & ~irqClr) | irqSet;
            faultPrev <= faultLvl;
            irq       <= (irqStat[`SPC_IRQ_MATCH] & irqMask[`SPC_IRQ_MATCH]
                          & matchIe)
                       | (irqStat[`SPC_IRQ_FAULT] & irqMask[`SPC_IRQ_FAULT]);
        end
    end

    // ****************************************
    // Slave select pin
    // ****************************************
    always @* begin
        next_selectOut  = 1'b1;
        next_selectOe   = 1'b0;
        next_selectGpio = 1'b0;
        if (!isMaster) begin
            // Select stays an input whatever fault enable says
            next_selectOe = 1'b0;
        end else if (!mode_fault_enable) begin
            next_selectGpio = 1'b1;
        end else if (selOe) begin
            // Automatic select, low during a transfer
            next_selectOe  = 1'b1;
            next_selectOut = ~xferActive;
        end
    end

    // ****************************************
    // Data pins
    // ****************************************
    always @* begin
        next_mosiOut = 1'b0;
        next_mosiOe  = 1'b0;
        next_misoOut = 1'b0;
        next_misoOe  = 1'b0;
        next_rxBit   = 1'b0;
        if (!singleWire) begin
            // Normal pins, bidir enable ignored
            if (isMaster) begin
                next_mosiOut = txBit;
                next_mosiOe  = 1'b1;
                next_rxBit   = misoSync;
            end else begin
                next_misoOut = txBit;
                next_misoOe  = 1'b1;
                next_rxBit   = mosiSync;
            end
        end else if (isMaster) begin
            // Single wire on MOSI, MISO left alone
            next_mosiOut = txBit;
            next_mosiOe  = bidir_output_enable;
            next_rxBit   = mosiSync;
        end else begin
            // Single wire on MISO, MOSI left alone
            next_misoOut = txBit;
            next_misoOe  = bidir_output_enable;
            next_rxBit   = misoSync;
        end
    end

    // ****************************************
    // Link clock edge and pin registers
    // ****************************************
    assign sckRise = sckSync & ~sckPrev;

    // Receive bit sampled on each link clock rise while port clocks run
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sckPrev    <= 1'b0;
            rxBit      <= 1'b0;
            rxStrobe   <= 1'b0;
            selectOut  <= 1'b1;
            selectOe   <= 1'b0;
            selectGpio <= 1'b0;
            mosiOut    <= 1'b0;
            mosiOe     <= 1'b0;
            misoOut    <= 1'b0;
            misoOe     <= 1'b0;
        end else begin
            sckPrev    <= sckSync;
            rxStrobe   <= sckRise & portClkEn;
            if (sckRise && portClkEn) begin
                rxBit <= next_rxBit;
            end
            selectOut  <= next_selectOut;
            selectOe   <= next_selectOe;
            selectGpio <= next_selectGpio;
            mosiOut    <= next_mosiOut;
            mosiOe     <= next_mosiOe;
            misoOut    <= next_misoOut;
            misoOe     <= next_misoOe;
        end
    end

    // ****************************************
    // Wait mode clock gate
    // ****************************************
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            portClkEn <= 1'b1;
        end else begin
            portClkEn <= ~(stopWait & cpuWait);
        end
    end
endmodule // spc_pin_ctrl
`default_nettype wire

// ==== dv/spc_pin_ctrl_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "spc_defines.vh"
// ****************************************
// Port checker
// ****************************************
module spc_pin_ctrl_monitor (
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        xferActive,
    input wire logic        cpuWait,
    input wire logic        sckPin,
    input wire logic        rxStrobe,
    input wire logic        portClkEn,
    input wire logic        selectOut,
    input wire logic        selectOe,
    input wire logic        selectGpio,
    input wire logic        mosiOe,
    input wire logic        misoOe
);
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Bus answers, clock gating, pin roles and link sampling
    property p_rdy; pready |-> psel && penable ##1 !pready; endproperty
    a_rdy: assert property (p_rdy) else $error("bad ready");
    property p_rdZero; pready && !pwrite && paddr == `SPC_ADDR_CTRL_TWO
        |-> prdata[31:8] == 24'h00_0000 && prdata[6:5] == 2'h0 && !prdata[2]; endproperty
    a_rdZero: assert property (p_rdZero) else $error("bad read bits");
    property p_clkRun; !cpuWait |=> portClkEn; endproperty
    a_clkRun: assert property (p_clkRun) else $error("clock stopped");
    property p_oneDrv; !(mosiOe && misoOe); endproperty
    a_oneDrv: assert property (p_oneDrv) else $error("two drivers");
    property p_gpio; selectGpio |-> !selectOe; endproperty
    a_gpio: assert property (p_gpio) else $error("gpio driven");
    property p_mstMiso; selectGpio || selectOe |-> !misoOe; endproperty
    a_mstMiso: assert property (p_mstMiso) else $error("miso driven");
    property p_selOut; selectOe && $past(selectOe) |-> selectOut == !$past(xferActive);
    endproperty
    a_selOut: assert property (p_selOut) else $error("select level");
    property p_rxSeen; $rose(sckPin) |-> ##[1:5] (rxStrobe || !portClkEn); endproperty
    a_rxSeen: assert property (p_rxSeen) else $error("edge missed");
endmodule // spc_pin_ctrl_monitor
bind spc_pin_ctrl spc_pin_ctrl_monitor mon_u (.*);
`default_nettype wire

// ==== dv/spc_far_dev.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Far side link device
// ****************************************
module spc_far_dev (
    input  wire logic       frameGo,
    input  wire logic [7:0] txByte,
    input  wire logic       mosiOut,
    input  wire logic       mosiOe,
    input  wire logic       misoOut,
    input  wire logic       misoOe,
    output var  logic       sckPin,
    output var  logic       selectIn,
    output var  logic       busy,
    output wire logic       mosiIn,
    output wire logic       misoIn
);
    logic bitVal;
    // Chip driver wins; outside a frame the line shows the inverse of the last bit
    assign mosiIn = mosiOe ? mosiOut : (busy ? bitVal : ~bitVal);
    assign misoIn = misoOe ? misoOut : (busy ? bitVal : ~bitVal);
    // Idle: clock low, select high
    initial begin
        {sckPin, selectIn, busy, bitVal} = 4'b0100;
    end
    // One byte, top bit first, link clock runs only inside the frame
    always @(posedge frameGo) begin
        #3 {busy, selectIn} = 2'b10;
        for (int k = 7; k >= 0; k--) begin
            bitVal = txByte[k];
            #80 sckPin = 1'b1;
            #80 sckPin = 1'b0;
        end
        #80 {busy, selectIn} = 2'b01;
    end
endmodule // spc_far_dev
`default_nettype wire

// ==== dv/spc_pin_ctrl_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "spc_defines.vh"
// ****************************************
// Pin control bench
// ****************************************
module spc_pin_ctrl_tb;
    logic        core_clk, resetn, psel, penable, pwrite, pready, pslverr, rdErr, busy;
    logic        matchEvent, xferActive, txBit, cpuWait, rxBit, rxStrobe, portClkEn, irq;
    logic        sckPin, selectIn, selectOut, selectOe, selectGpio, frameGo, strobeD;
    logic        mosiIn, mosiOut, mosiOe, misoIn, misoOut, misoOe, stopped;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rdData;
    logic [7:0]  txByte, rxShift, c;
    logic [1:0]  md;
    int          fail_count, n_compared, rxCnt, base, i;
    spc_pin_ctrl dut_u (.*);
    spc_far_dev far_u (.*);
    // 100 MHz core clock
    always #5 core_clk = ~core_clk;
    // Collect each received bit one cycle after its strobe
    always @(posedge core_clk) begin
        strobeD <= rxStrobe;
        if (strobeD === 1'b1) begin
            rxShift <= {rxShift[6:0], rxBit};
            rxCnt   <= rxCnt + 1;
        end
    end
    // Expected {mosiOe, misoOe, selectOe, selectGpio} from mode and control two
    function automatic logic [3:0] ep(input logic [1:0] m, input logic [7:0] c2);
        return {c2[0] ? m[0] & c2[3] : m[0], c2[0] ? !m[0] & c2[3] : !m[0],
                m[0] & c2[4] & m[1], m[0] & !c2[4]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask
    // One bus transfer, held until ready is sampled
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1);
        rdData = prdata;
        rdErr = pslverr;
        {psel, penable} <= 2'b00;
        // Zero wait states: ready comes in the first access cycle
        chk("waits", 1, n);
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rdData);
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        core_clk = 1'b0;
        resetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {matchEvent, xferActive, txBit, cpuWait, frameGo, txByte} = '0;
        void'($urandom(24953));
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        for (i = 0; i < 4; i++) rd(`SPC_ADDR_CTRL_TWO + 16'(4 * i), 0, "reset");
        apb(1'b0, 16'hC274, 32'h0000_0000);
        chk("slverr", 1, rdErr);
        for (i = 0; i < 24; i++) begin
            c = 8'($urandom) & 8'hDB;
            md = 2'($urandom);
            if (i < 8) {c[3], c[0], md[0]} = 3'(i);
            if (i == 8) c = 8'hDB;
            {xferActive, txBit, cpuWait} <= 3'($urandom);
            apb(1'b1, `SPC_ADDR_CTRL_TWO, 32'(c));
            apb(1'b1, `SPC_ADDR_MODE, 32'(md));
            rd(`SPC_ADDR_CTRL_TWO, 32'(c & 8'h9B), "ctrlTwo");
            chk("oe", ep(md, c), {mosiOe, misoOe, selectOe, selectGpio});
            chk("clkEn", !(c[1] & cpuWait), portClkEn);
            txByte <= 8'($urandom);
            frameGo <= 1'b1;
            base = rxCnt;
            @(posedge core_clk);
            frameGo <= 1'b0;
            @(negedge busy);
            repeat (8) @(posedge core_clk);
            stopped = c[1] & cpuWait;
            chk("rxCount", stopped ? 0 : 8, rxCnt - base);
            if (!stopped && !(c[0] & c[3])) chk("rxByte", txByte, rxShift);
            else if (!stopped) chk("loopBack", {8{txBit}}, rxShift);
            // Select pulled low in the frame is a fault only when it is the fault input
            rd(`SPC_ADDR_IRQ_STAT, 32'({md[0] & c[4] & !md[1], 1'b0}), "fault");
            apb(1'b1, `SPC_ADDR_IRQ_STAT, 32'h0000_0003);
        end
        apb(1'b1, `SPC_ADDR_MODE, 32'h0000_0000);
        apb(1'b1, `SPC_ADDR_IRQ_STAT, 32'h0000_0003);
        for (i = 0; i < 4; i++) begin
            apb(1'b1, `SPC_ADDR_CTRL_TWO, 32'(i[0]) << 7);
            apb(1'b1, `SPC_ADDR_IRQ_MASK, 32'(i[1]));
            matchEvent <= 1'b1;
            @(posedge core_clk);
            matchEvent <= 1'b0;
            repeat (3) @(posedge core_clk);
            chk("irq", i[0] & i[1], irq);
            rd(`SPC_ADDR_IRQ_STAT, 1, "matchFlag");
            apb(1'b1, `SPC_ADDR_IRQ_STAT, 32'h0000_0001);
            repeat (3) @(posedge core_clk);
            chk("irqOff", 0, irq);
        end
        close_out();
    end
    // Watchdog, far beyond the few tens of microseconds the tests need
    initial begin
        #400_000;
        fail_count++;
        close_out();
    end
endmodule // spc_pin_ctrl_tb
`default_nettype wire
